// *** ddr_cfg_map.svh ***
// Register map, field positions, encodings and timing counts of the DDR configuration block
`ifndef DDR_CFG_MAP_SVH
`define DDR_CFG_MAP_SVH

// ----------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------
`define ADDR_W 12
`define TIMING_CFG_ADDR 12'h078
`define MODE_CTRL_ADDR 12'h07c
`define TIMING_RESET 32'h0000_0010
`define MODE_RESET 32'h0000_0000
`define TIMING_WMASK 32'h0007_0635
`define MODE_WMASK 32'h3f30_0770

// ----------------------------------------------------------------
// Fields of the timing register
// ----------------------------------------------------------------
`define IDLE_F 18:16
`define RAS_F 10:9
`define CL_F 5:4
`define RCD_BIT 2
`define RP_BIT 0

// ----------------------------------------------------------------
// Fields of the mode register
// ----------------------------------------------------------------
`define REV_F 31:30
`define INIT_BIT 29
`define PDN_BIT 28
`define ROWS_F 27:24
`define DIM_F 21:20
`define REF_F 10:8
`define SMS_F 6:4

// ----------------------------------------------------------------
// Encodings and decoded counts
// ----------------------------------------------------------------
`define IDLE_NEVER 3'h0
`define IDLE_ZERO 3'h1
`define IDLE_8 3'h2
`define IDLE_16 3'h3
`define IDLE_64 3'h4
`define IDLE_CYC_0 8'h00
`define IDLE_CYC_8 8'h08
`define IDLE_CYC_16 8'h10
`define IDLE_CYC_64 8'h40
`define RAS_CODE_7 2'h0
`define RAS_CODE_6 2'h1
`define RAS_CODE_5 2'h2
`define RAS_7 3'h7
`define RAS_6 3'h6
`define RAS_5 3'h5
`define CL_CODE_2_5 2'h0
`define CL_CODE_2 2'h1
`define CL_2_5_HALF 3'h5
`define CL_2_HALF 3'h4
`define RCD_3 2'h3
`define RCD_2 2'h2
`define RP_3 2'h3
`define RP_2 2'h2
`define SMS_POST_RESET 3'h0
`define REF_OFF 3'h0
`define REF_15_6 3'h1
`define REF_7_8 3'h2
`define REF_64US 3'h3
`define REF_FAST 3'h7

// ----------------------------------------------------------------
// Refresh timing
// ----------------------------------------------------------------
`define CLK_MHZ 250
`define REF_15_6_NS 15600
`define REF_7_8_NS 7800
`define REF_64_US 64
`define REF_FAST_CLKS 64
`define NS_TO_CYC(ns) ((ns) * `CLK_MHZ / 1000)
`define US_TO_CYC(us) ((us) * `CLK_MHZ)
`define TMR_W 16
`define ROW_PAIRS 2

`endif

// *** ddr_cfg_pkg.sv ***
// Types shared by the DDR configuration block and its interval ticker
package ddr_cfg_pkg;
`include "ddr_cfg_map.svh"

    typedef logic [`TMR_W-1:0] period_t;

    typedef struct packed {
        logic [31:0] timing;
        logic [31:0] mode;
        logic ckeArmed;
        logic [`ROW_PAIRS-1:0] cke;
        logic [7:0] idleCnt;
        logic idleFired;
        logic prechargeAll;
        logic [2:0] rasClk;
        logic [2:0] casHalf;
        logic [1:0] rcdClk;
        logic [1:0] rpClk;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cfgState_t;

    typedef struct packed {
        period_t cnt;
        logic tick;
    } tickState_t;

endpackage

// *** interval_ticker.sv ***
// Free-running interval counter that pulses once per programmed period
`timescale 1ns/100ps
module interval_ticker
    import ddr_cfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic run,
    input wire period_t period,
    output logic tick
);
    tickState_t st_q;
    tickState_t st_d;

    // Period change mid-count takes effect at the next wrap or earlier
    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (!run) begin
            st_d.cnt = '0;
        end else if (st_q.cnt >= period - period_t'(1)) begin
            st_d.cnt = '0;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + period_t'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

    a_tick_needs_run: assert property (@(posedge core_clk) disable iff (srst)
        !run |=> !tick)
        else $error("tick while stopped");
endmodule

// *** ddr_timing_mode_config.sv ***
// DDR controller timing and mode registers with CKE, idle and refresh control
//
// Functional notes
// R1: Idle timer code gives clocks idle before precharge-all: never, 0, 8, 16, 64.
// R2: Activate-to-precharge code 00/01/10 gives 7/6/5 clocks; 11 reserved.
// R3: Read latency code 00 gives 2.5 clocks, 01 gives 2; others reserved.
// R4: Activate-to-column bit: 0 gives 3 clocks (default), 1 gives 2.
// R5: Precharge-to-activate bit: 0 gives 3 clocks (default), 1 gives 2.
// R6: Format revision field always holds 00.
// R7: Init-done flag is software state; firmware sets it after memory init.
// R8: With power-down enabled, a precharged row pair sleeps; access wakes it.
// R9: Power-down entry drops clock enable, exit raises it again.
// R10: Active-rows field limits open rows; all codes here allow every row.
// R11: Two-bit data-integrity field selects one of four modes.
// R12: Refresh field disables refresh or picks an interval.
// R13: Refresh code 011 gives 64 us, code 111 gives 64 clocks.
// R14: Refresh code 000 disables, 001 gives 15.6 us, 010 gives 7.8 us.
// R15: Reserved bits read zero and ignore writes.
// R16: Clock enables stay low after reset until special mode written nonzero.
`timescale 1ns/100ps
`include "ddr_cfg_map.svh"
module ddr_timing_mode_config
    import ddr_cfg_pkg::*;
#(
    parameter period_t REF_64US_CYC = period_t'(`US_TO_CYC(`REF_64_US))
)
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic controllerIdle,
    input wire logic [`ROW_PAIRS-1:0] pairPrecharged,
    input wire logic [`ROW_PAIRS-1:0] pairAccess,
    output logic [`ROW_PAIRS-1:0] cke,
    output logic prechargeAllReq,
    output logic refreshReq,
    output logic [2:0] rasClocks,
    output logic [2:0] casLatencyHalf,
    output logic [1:0] rcdClocks,
    output logic [1:0] rpClocks,
    output logic [3:0] activeRowLimit,
    output logic [1:0] integrityMode,
    output logic [2:0] specialMode,
    output logic powerDownEnable,
    output logic initDone
);
    // ----------------------------------------------------------------
    // Constants and helpers
    // ----------------------------------------------------------------
    localparam period_t REF_15_6_CYC = period_t'(`NS_TO_CYC(`REF_15_6_NS));
    localparam period_t REF_7_8_CYC = period_t'(`NS_TO_CYC(`REF_7_8_NS));
    localparam period_t REF_FAST_CYC = period_t'(`REF_FAST_CLKS);

    localparam cfgState_t RST_STATE = '{
        timing: `TIMING_RESET,
        mode: `MODE_RESET,
        rasClk: `RAS_7,
        casHalf: `CL_2_HALF,
        rcdClk: `RCD_3,
        rpClk: `RP_3,
        default: '0
    };

    // Byte lanes from pstrb, limited to implemented bits
    function automatic logic [31:0] mergeWrite(
        input logic [31:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb,
        input logic [31:0] wmask
    );
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        m = m & wmask;
        return (old & ~m) | (wdata & m);
    endfunction

    // Zero period means refresh is off; reserved codes also stop it
    function automatic period_t refreshPeriod(input logic [2:0] code);
        period_t p;
        p = '0;
        unique case (code)
            `REF_15_6: p = REF_15_6_CYC;
            `REF_7_8: p = REF_7_8_CYC;
            `REF_64US: p = REF_64US_CYC;
            `REF_FAST: p = REF_FAST_CYC;
            default: p = '0;
        endcase
        return p;
    endfunction

    cfgState_t st_q;
    cfgState_t st_d;
    logic hitTiming;
    logic hitMode;
    logic accessEdge;
    logic wrTiming;
    logic wrMode;
    logic [31:0] newMode;
    period_t refPeriod;
    logic refRun;

    assign hitTiming = (paddr == `TIMING_CFG_ADDR);
    assign hitMode = (paddr == `MODE_CTRL_ADDR);
    assign accessEdge = psel && penable && st_q.pready;
    assign wrTiming = accessEdge && pwrite && hitTiming;
    assign wrMode = accessEdge && pwrite && hitMode;
    assign newMode = mergeWrite(st_q.mode, pwdata, pstrb, `MODE_WMASK); // [R6] [R15]
    assign refPeriod = refreshPeriod(st_q.mode[`REF_F]); // [R12] [R13] [R14]
    assign refRun = (refPeriod != '0);

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [7:0] idleLimit;
        logic idleOn;
        idleLimit = `IDLE_CYC_0;
        idleOn = 1'b1;
        st_d = st_q;

        // Bus slave: read data sampled in setup, answered in first access cycle
        st_d.pready = psel && !penable;
        st_d.pslverr = 1'b0;
        st_d.prdata = '0;
        if (psel && !penable) begin
            if (hitTiming) begin
                st_d.prdata = st_q.timing & `TIMING_WMASK; // [R15]
            end else if (hitMode) begin
                st_d.prdata = st_q.mode & `MODE_WMASK; // [R6] [R15]
            end else begin
                st_d.pslverr = 1'b1;
            end
        end

        if (wrTiming) begin
            st_d.timing = mergeWrite(st_q.timing, pwdata, pstrb, `TIMING_WMASK); // [R15]
        end
        if (wrMode) begin
            st_d.mode = newMode; // [R7] [R10] [R11]
            if (newMode[`SMS_F] != `SMS_POST_RESET) begin
                st_d.ckeArmed = 1'b1; // [R16]
            end
        end

        // Decoded timings; reserved codes fall back to the slowest setting
        unique case (st_q.timing[`RAS_F])
            `RAS_CODE_6: st_d.rasClk = `RAS_6; // [R2]
            `RAS_CODE_5: st_d.rasClk = `RAS_5; // [R2]
            default: st_d.rasClk = `RAS_7; // [R2]
        endcase
        unique case (st_q.timing[`CL_F])
            `CL_CODE_2: st_d.casHalf = `CL_2_HALF; // [R3]
            default: st_d.casHalf = `CL_2_5_HALF; // [R3]
        endcase
        st_d.rcdClk = st_q.timing[`RCD_BIT] ? `RCD_2 : `RCD_3; // [R4]
        st_d.rpClk = st_q.timing[`RP_BIT] ? `RP_2 : `RP_3; // [R5]

        // ----------------------------------------------------------------
        // Idle precharge timer
        // ----------------------------------------------------------------
        unique case (st_q.timing[`IDLE_F])
            `IDLE_ZERO: idleLimit = `IDLE_CYC_0;
            `IDLE_8: idleLimit = `IDLE_CYC_8;
            `IDLE_16: idleLimit = `IDLE_CYC_16;
            `IDLE_64: idleLimit = `IDLE_CYC_64;
            default: idleOn = 1'b0;
        endcase
        st_d.prechargeAll = 1'b0;
        if (!controllerIdle) begin
            st_d.idleCnt = '0;
            st_d.idleFired = 1'b0;
        end else if (idleOn && !st_q.idleFired && st_q.idleCnt >= idleLimit) begin
            // One precharge-all per idle stretch
            st_d.prechargeAll = 1'b1; // [R1]
            st_d.idleFired = 1'b1;
        end else if (st_q.idleCnt != 8'hff) begin
            st_d.idleCnt = st_q.idleCnt + 8'h01; // [R1]
        end

        // ----------------------------------------------------------------
        // Clock enable per row pair
        // ----------------------------------------------------------------
        for (int p = 0; p < `ROW_PAIRS; p++) begin
            if (!st_q.ckeArmed) begin
                // Arming write wakes every pair, even with power-down already enabled
                st_d.cke[p] = st_d.ckeArmed; // [R16]
            end else if (pairAccess[p] || !st_q.mode[`PDN_BIT]) begin
                st_d.cke[p] = 1'b1; // [R8] [R9]
            end else if (pairPrecharged[p]) begin
                st_d.cke[p] = 1'b0; // [R8] [R9]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q <= RST_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------------------------------
    // Refresh interval
    // ----------------------------------------------------------------
    interval_ticker refreshTicker (
        .core_clk(core_clk),
        .srst(srst),
        .run(refRun),
        .period(refPeriod),
        .tick(refreshReq)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign prdata = st_q.prdata;
    assign pready = st_q.pready;
    assign pslverr = st_q.pslverr;
    assign cke = st_q.cke;
    assign prechargeAllReq = st_q.prechargeAll;
    assign rasClocks = st_q.rasClk;
    assign casLatencyHalf = st_q.casHalf;
    assign rcdClocks = st_q.rcdClk;
    assign rpClocks = st_q.rpClk;
    assign activeRowLimit = st_q.mode[`ROWS_F]; // [R10]
    assign integrityMode = st_q.mode[`DIM_F]; // [R11]
    assign specialMode = st_q.mode[`SMS_F];
    assign powerDownEnable = st_q.mode[`PDN_BIT];
    assign initDone = st_q.mode[`INIT_BIT]; // [R7]

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_idle_never_fires: assert property ( // [R1]
        @(posedge core_clk) disable iff (srst)
        st_q.timing[`IDLE_F] == `IDLE_NEVER |=> !prechargeAllReq)
        else $error("precharge-all with idle timer off");

    a_idle_zero_prompt: assert property ( // [R1]
        @(posedge core_clk) disable iff (srst)
        (st_q.timing[`IDLE_F] == `IDLE_ZERO && !controllerIdle ##1 controllerIdle
            && $stable(st_q.timing)) |=> prechargeAllReq)
        else $error("zero idle code did not precharge at once");

    a_ras_decode: assert property ( // [R2]
        @(posedge core_clk) disable iff (srst)
        (st_q.timing[`RAS_F] == `RAS_CODE_5)[*2] |-> rasClocks == `RAS_5)
        else $error("activate-to-precharge decode wrong");

    a_cl_decode: assert property ( // [R3]
        @(posedge core_clk) disable iff (srst)
        (st_q.timing[`CL_F] == `CL_CODE_2_5)[*2] |-> casLatencyHalf == `CL_2_5_HALF)
        else $error("read latency decode wrong");

    a_rcd_rp_decode: assert property ( // [R4] [R5]
        @(posedge core_clk) disable iff (srst)
        ##1 (rcdClocks == ($past(st_q.timing[`RCD_BIT]) ? `RCD_2 : `RCD_3))
            && (rpClocks == ($past(st_q.timing[`RP_BIT]) ? `RP_2 : `RP_3)))
        else $error("row timing decode wrong");

    a_rev_reads_zero: assert property ( // [R6] [R15]
        @(posedge core_clk) disable iff (srst)
        (pready && hitMode) |-> (prdata & ~`MODE_WMASK) == '0)
        else $error("reserved or revision bits read nonzero");

    a_init_flag_set: assert property ( // [R7]
        @(posedge core_clk) disable iff (srst)
        (wrMode && pstrb[3] && pwdata[`INIT_BIT]) |=> initDone)
        else $error("init-done flag not stored");

    a_cke_held_low: assert property ( // [R16]
        @(posedge core_clk) disable iff (srst)
        !st_q.ckeArmed |-> cke == '0)
        else $error("clock enable raised before special mode write");

    a_cke_arm_write: assert property ( // [R16] [R9]
        @(posedge core_clk) disable iff (srst)
        (wrMode && pstrb[0] && pwdata[`SMS_F] != `SMS_POST_RESET && !powerDownEnable
            && !(pstrb[3] && pwdata[`PDN_BIT])) |=> ##1 cke == '1)
        else $error("clock enables not raised after special mode write");

    a_pdn_entry: assert property ( // [R8] [R9]
        @(posedge core_clk) disable iff (srst)
        (st_q.ckeArmed && powerDownEnable && pairPrecharged[0] && !pairAccess[0])
            |=> !cke[0])
        else $error("row pair did not enter power-down");

    a_refresh_off: assert property ( // [R14]
        @(posedge core_clk) disable iff (srst)
        st_q.mode[`REF_F] == `REF_OFF |=> !refreshReq)
        else $error("refresh issued while disabled");

    a_fast_spacing: assert property ( // [R13]
        @(posedge core_clk) disable iff (srst)
        (refreshReq && st_q.mode[`REF_F] == `REF_FAST) |=> !refreshReq [*8])
        else $error("fast refresh spaced too closely");
endmodule

// *** ddr_mem_partner.sv ***
// Behavioural stand-in for the DRAM command side of the configuration block
`timescale 1ns/100ps
`include "ddr_cfg_map.svh"
module ddr_mem_partner (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic idleCmd,
    input wire logic [`ROW_PAIRS-1:0] closeCmd,
    input wire logic [`ROW_PAIRS-1:0] accessCmd,
    input wire logic refreshReq,
    output logic controllerIdle,
    output logic [`ROW_PAIRS-1:0] pairPrecharged,
    output logic [`ROW_PAIRS-1:0] pairAccess,
    output logic [15:0] refreshCount
);
    typedef struct packed {
        logic idle;
        logic [`ROW_PAIRS-1:0] closed;
        logic [`ROW_PAIRS-1:0] busy;
        logic [15:0] refreshes;
    } memState_t;
    memState_t state_q, state_d;
    // Bank state follows the bench one clock later, like a real command queue
    always_comb begin
        state_d = state_q;
        state_d.idle = idleCmd;
        state_d.closed = closeCmd;
        state_d.busy = accessCmd;
        if (refreshReq === 1'b1) state_d.refreshes = state_q.refreshes + 16'h0001;
        if (srst) state_d = '0;
    end
    always_ff @(posedge core_clk) begin
        state_q <= state_d;
    end
    assign controllerIdle = state_q.idle;
    assign pairPrecharged = state_q.closed;
    assign pairAccess = state_q.busy;
    assign refreshCount = state_q.refreshes;
endmodule

// *** tb_ddr_timing_mode_config.sv ***
// Self-checking bench of the DDR timing and mode register block
`timescale 1ns/100ps
`include "ddr_cfg_map.svh"
module tb_ddr_timing_mode_config;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic idleCmd = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [1:0] closeCmd = 2'h0;
    logic [1:0] accessCmd = 2'h0;
    logic [31:0] prdata, d, rd, t;
    logic pready, pslverr, ctlIdle, preAll, refreshReq, pdnEn, initDone, err, idlePrev;
    logic [1:0] pairPre, pairAcc, cke, rcd, rp, dim;
    logic [2:0] ras, cl, special_mode_select;
    logic [3:0] rows;
    logic [15:0] refCnt, r0;
    logic [2:0] refCodes [6] = '{3'h7, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4};
    int fails = 0;
    int checks = 0;
    int cyc = 0;
    int pulses = 0;
    int idleAt, preAt, refA, refB, n0, w;

    always #2 core_clk = ~core_clk;

    // 64 us count shortened to 100 clocks to keep the run short
    ddr_timing_mode_config #(.REF_64US_CYC(16'h0064)) dut (
        .core_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .controllerIdle(ctlIdle), .pairPrecharged(pairPre),
        .pairAccess(pairAcc), .cke, .prechargeAllReq(preAll), .refreshReq,
        .rasClocks(ras), .casLatencyHalf(cl), .rcdClocks(rcd), .rpClocks(rp),
        .activeRowLimit(rows), .integrityMode(dim), .specialMode(special_mode_select),
        .powerDownEnable(pdnEn), .initDone
    );
    ddr_mem_partner mem (
        .core_clk, .srst, .idleCmd, .closeCmd, .accessCmd, .refreshReq,
        .controllerIdle(ctlIdle), .pairPrecharged(pairPre), .pairAccess(pairAcc),
        .refreshCount(refCnt)
    );

    // ----------------------------------------------------------------
    // Pulse monitor
    // ----------------------------------------------------------------
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        idlePrev <= ctlIdle;
        if (ctlIdle === 1'b1 && idlePrev !== 1'b1) idleAt <= cyc;
        if (preAll === 1'b1) preAt <= cyc;
        if (preAll === 1'b1) pulses <= pulses + 1;
        if (refreshReq === 1'b1) refB <= refA;
        if (refreshReq === 1'b1) refA <= cyc;
    end

    // ----------------------------------------------------------------
    // Expectations and checks
    // ----------------------------------------------------------------
    function automatic int idleExp(input logic [2:0] c);
        case (c)
            3'h1: return 1;
            3'h2: return 9;
            3'h3: return 17;
            3'h4: return 65;
            default: return 0;
        endcase
    endfunction
    // Periods in 4 ns clocks; zero means no refresh at all
    function automatic int refExp(input logic [2:0] c);
        case (c)
            3'h1: return 15600 / 4;
            3'h2: return 7800 / 4;
            3'h3: return 100;
            3'h7: return 64;
            default: return 0;
        endcase
    endfunction
    task automatic chkv(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chkn(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            fails++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       input logic [3:0] st);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        chkn("pready wait", 1, int'(n < 50));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Decoded outputs trail the register by one clock
    task automatic wreg(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
        apb(1'b1, a, wd, st);
        repeat (2) @(posedge core_clk);
    endtask
    task automatic report_and_stop;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge core_clk);
        fails++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        d = $urandom(27);
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        apb(1'b0, `TIMING_CFG_ADDR, 32'h0, 4'hf);
        chkv("timing reset", `TIMING_RESET, rd);
        chkv("cas reset", 3'h4, cl);
        apb(1'b0, `MODE_CTRL_ADDR, 32'h0, 4'hf);
        chkv("mode reset", `MODE_RESET, rd);
        $display("test reset done");
        for (int i = 0; i < 20; i++) begin
            d = $urandom;
            if (i < 4) d[10:9] = i[1:0];
            if (i < 4) d[5:4] = i[1:0];
            wreg(`TIMING_CFG_ADDR, d, 4'hf);
            apb(1'b0, `TIMING_CFG_ADDR, 32'h0, 4'hf);
            chkv("timing readback", d & `TIMING_WMASK, rd);
            chkv("ras", (d[10:9] == 2'h1) ? 3'h6 : (d[10:9] == 2'h2) ? 3'h5 : 3'h7, ras);
            chkv("cas", (d[5:4] == 2'h1) ? 3'h4 : 3'h5, cl);
            chkv("rcd", d[2] ? 2'h2 : 2'h3, rcd);
            chkv("rp", d[0] ? 2'h2 : 2'h3, rp);
        end
        t = (d & `TIMING_WMASK & 32'hffff_ff00) | (`TIMING_WMASK & 32'h0000_00ff);
        wreg(`TIMING_CFG_ADDR, 32'hffff_ffff, 4'h1);
        apb(1'b1, 12'h080, 32'hffff_ffff, 4'hf);
        chkv("unmapped write err", 1'b1, err);
        apb(1'b0, 12'h074, 32'h0, 4'hf);
        chkv("unmapped read err", 1'b1, err);
        chkv("unmapped read data", 32'h0, rd);
        apb(1'b0, `TIMING_CFG_ADDR, 32'h0, 4'hf);
        chkv("strobe merge", t, rd);
        $display("test timing done");
        for (int i = 0; i < 12; i++) begin
            d = (i == 0) ? 32'hffff_ff8f : ($urandom & 32'hffff_f88f);
            wreg(`MODE_CTRL_ADDR, d, 4'hf);
            apb(1'b0, `MODE_CTRL_ADDR, 32'h0, 4'hf);
            chkv("mode readback", d & `MODE_WMASK, rd);
            chkv("rows", d[27:24], rows);
            chkv("integrity", d[21:20], dim);
            chkv("fields", {d[29:28], 3'h0}, {initDone, pdnEn, special_mode_select});
            chkv("cke unarmed", 2'h0, cke);
        end
        $display("test mode done");
        wreg(`MODE_CTRL_ADDR, 32'h0000_0070, 4'hf);
        chkv("cke armed", 2'h3, cke);
        chkv("special mode", 3'h7, special_mode_select);
        wreg(`MODE_CTRL_ADDR, 32'h1000_0070, 4'hf);
        closeCmd <= 2'h1;
        repeat (4) @(posedge core_clk);
        chkv("cke pair0 down", 2'h2, cke);
        accessCmd <= 2'h1;
        repeat (4) @(posedge core_clk);
        chkv("cke pair0 woken", 2'h3, cke);
        closeCmd <= 2'h3;
        repeat (4) @(posedge core_clk);
        chkv("cke access wins", 2'h1, cke);
        wreg(`MODE_CTRL_ADDR, 32'h0000_0070, 4'hf);
        chkv("cke pdn off", 2'h3, cke);
        closeCmd <= 2'h0;
        accessCmd <= 2'h0;
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        wreg(`MODE_CTRL_ADDR, 32'h1000_0000, 4'hf);
        chkv("cke after rereset", 2'h0, cke);
        wreg(`MODE_CTRL_ADDR, 32'h1000_0070, 4'hf);
        chkv("cke arm with pdn", 2'h3, cke);
        $display("test cke done");
        for (int c = 0; c < 6; c++) begin
            idleCmd <= 1'b0;
            wreg(`TIMING_CFG_ADDR, {13'h0, c[2:0], 16'h0010}, 4'hf);
            n0 = pulses;
            idleCmd <= 1'b1;
            repeat (80) @(posedge core_clk);
            chkn("idle pulses", int'(idleExp(c[2:0]) != 0), pulses - n0);
            if (idleExp(c[2:0]) != 0) chkn("idle delay", idleExp(c[2:0]), preAt - idleAt);
        end
        idleCmd <= 1'b0;
        $display("test idle done");
        foreach (refCodes[k]) begin
            wreg(`MODE_CTRL_ADDR, {21'h0, refCodes[k], 8'h0}, 4'hf);
            r0 = refCnt;
            w = 0;
            while (int'(refCnt - r0) < 3 && w < 3 * refExp(refCodes[k]) + 300) begin
                @(posedge core_clk);
                w++;
            end
            @(posedge core_clk);
            if (refExp(refCodes[k]) != 0) begin
                chkn("refresh period", refExp(refCodes[k]), refA - refB);
            end else begin
                chkn("refresh off", 0, int'(refCnt - r0));
            end
        end
        $display("test refresh done");
        report_and_stop();
    end
endmodule
